/* design/mipu_enc_if.sv */
// Carrier between the priority core and its encoder.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/100ps
interface mipu_enc_if;
	logic [5:0] pending;
	logic [2:0] code;
	logic any;
	modport core (output pending, input code, input any);
	modport enc (input pending, output code, output any);
endinterface : mipu_enc_if

/* design/mipu_encoder.sv */
// Priority encoder for six user-level sources.
// Assumes level 5 is highest; pure combinational logic.
`timescale 1ns/100ps
module mipu_encoder (
	mipu_enc_if.enc bus
);
	always_comb begin
		bus.code = 3'h0;
		bus.any = |bus.pending;
		for (int i = 0; i < mipu_pkg::NUM_SRC; i++) begin
			if (bus.pending[i]) begin
				bus.code = 3'(i);
			end
		end
	end
endmodule : mipu_encoder

/* design/mipu_pkg.sv */
// Constants for the user-level interrupt priority unit.
// Assumes one 100 MHz processor clock and an active-high system clear.
package mipu_pkg;
	localparam int CLK_MHZ = 100;
	localparam int SHUTDOWN_DELAY_US = 1000;
	localparam int SHUTDOWN_DELAY_CYC = SHUTDOWN_DELAY_US * CLK_MHZ;
	localparam int NUM_SRC = 6;
	localparam int LVL_CONSOLE = 5;
	localparam int LVL_PRIMARY_PF = 4;
	localparam int LVL_EARLY_PF = 3;
	localparam int LVL_IO_ATTN = 2;
	localparam int LVL_DMA_BAD = 1;
	localparam int LVL_DMA_END = 0;
	// Vector addresses by level, low to high
	localparam logic [11:0] VEC_L0 = 12'hDFF;
	localparam logic [11:0] VEC_L1 = 12'hDF7;
	localparam logic [11:0] VEC_L2 = 12'hDFB;
	localparam logic [11:0] VEC_L3 = 12'hDF3;
	localparam logic [11:0] VEC_L4 = 12'hDFD;
	localparam logic [11:0] VEC_L5 = 12'hDF5;
	localparam logic [23:0] SAVE_PTR_ADDR = 24'h00_0084;
	localparam logic [23:0] CONSOLE_FLAG_ADDR = 24'h00_0028;
	localparam logic [9:0] OFS_STATUS = 10'h000;
	localparam logic [9:0] OFS_REGSETS = 10'h008;
	localparam logic [9:0] OFS_SCRATCH = 10'h208;
	localparam logic [9:0] OFS_FLOAT = 10'h248;
	localparam logic [9:0] OFS_END = 10'h2A8;
	localparam int PSW_BIT_BRK_EN = 23;
	localparam int PSW_BIT_MALF = 18;
	typedef enum logic [4:0] {
		PF_IDLE = 5'b0_0001,
		PF_WAIT = 5'b0_0010,
		PF_PTR = 5'b0_0100,
		PF_SAVE = 5'b0_1000,
		PF_HOLD = 5'b1_0000
	} mipu_pf_state_t;
endpackage : mipu_pkg

/* design/mipu_top.sv */
// User-level interrupt priority unit with power-fail save sequencer.
// Assumes synchronous one-cycle event pulses and a sequencer acknowledge.
//
// Local design decisions: the address map.
`timescale 1ns/100ps
// Contract
// - Six sources go into an encoder producing a distinct 3-bit code.
// - A summary request accompanies every presented code.
// - Serviced code selects vector DF3 through DFF.
// - Mask bit suppresses the summary request.
// - Priority order: console, primary pf, early pf, io, dma bad, dma end.
// - Console mode: breakpoint with bit 23 clear, single step, halt/run press in run mode.
// - After init without loader: power lost, or kept and console flag set.
// - Uncorrectable error fetching malfunction status raises console attention.
// - Console attention holds other I/O requests until run mode.
// - Early power fail on low voltage, switch to standby, or init press.
// - Bit 18 set gives machine malfunction at instruction boundary.
// - One millisecond after early fail, shutdown fetches pointer at 84.
// - Save status, register sets, scratchpad, float regs; then wait restore.
// - Save pointer low two bits forced to zero.
// - Float and scratchpad always saved regardless of mask bits.
// - Early power fail interrupt needs a low voltage, standby or init press detect and bit 18.
// - After early fail acknowledge, lower levels are ignored.
// - Main or private bus attention merges into maskable io attention.
// - Bad status from command, controller status, or check line.
// - Unserviced termination re-raised through bad status on re-enable.
// - Good end when sync arrives while word count done.
module mipu_top #(
	parameter int SHUTDOWN_CYC = mipu_pkg::SHUTDOWN_DELAY_CYC
) (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic user_irq_mask_bit_in,
	input wire logic psw_bit23_in,
	input wire logic psw_bit18_in,
	input wire logic console_mode_in,
	input wire logic run_mode_in,
	input wire logic breakpoint_instruction_in,
	input wire logic single_step_done_in,
	input wire logic halt_run_press_in,
	input wire logic init_done_in,
	input wire logic loader_storage_unit_en_in,
	input wire logic backup_power_kept_in,
	input wire logic malf_fetch_uncorr_in,
	input wire logic primary_power_fail_sensor_in,
	input wire logic low_voltage_in,
	input wire logic power_standby_in,
	input wire logic init_press_in,
	input wire logic instr_boundary_in,
	input wire logic main_bus_attention_in,
	input wire logic private_bus_attention_in,
	input wire logic bad_termination_command_in,
	input wire logic ctrl_bad_status_in,
	input wire logic controller_check_line_in,
	input wire logic data_cmd_active_in,
	input wire logic word_count_done_in,
	input wire logic ctrl_sync_in,
	input wire logic vector_taken_in,
	input wire logic mem_ack_in,
	input wire logic [31:0] mem_rdata_in,
	input wire logic power_restore_in,
	output logic user_irq_summary_request_out,
	output logic [2:0] user_irq_code_out,
	output logic [11:0] vector_addr_out,
	output logic io_hold_out,
	output logic machine_malfunction_out,
	output logic mem_read_out,
	output logic mem_write_out,
	output logic [23:0] mem_addr_out,
	output logic [1:0] save_phase_out,
	output logic shutdown_busy_out,
	output logic wait_restore_out
);
	////////////////////////////////////////////////////////////////////////////
	function automatic logic [11:0] vec_of(input logic [2:0] c);
		logic [11:0] v;
		v = mipu_pkg::VEC_L0;
		unique case (c)
			3'h0: v = mipu_pkg::VEC_L0;
			3'h1: v = mipu_pkg::VEC_L1;
			3'h2: v = mipu_pkg::VEC_L2;
			3'h3: v = mipu_pkg::VEC_L3;
			3'h4: v = mipu_pkg::VEC_L4;
			3'h5: v = mipu_pkg::VEC_L5;
			default: v = mipu_pkg::VEC_L0;
		endcase
		return v;
	endfunction : vec_of

	////////////////////////////////////////////////////////////////////////////
	logic [5:0] pend_q;
	logic [5:0] pend_d;
	logic [5:0] set_v;
	logic [5:0] gate_v;
	logic pf_ack_q;
	logic term_lost_q;
	logic prev_mask_q;
	logic prev_low_q;
	logic prev_standby_q;
	logic init_done_prev_q;
	logic console_flag_pend_q;
	logic busy_q;
	logic ev_console;
	logic ev_early;
	logic ev_detect;
	logic ev_bad;
	logic ev_good;
	logic unmask_edge;
	mipu_enc_if enc_bus ();

	mipu_encoder u_enc (
		.bus(enc_bus)
	);

	always_comb begin
		ev_console = 1'b0;
		if (console_mode_in) begin
			ev_console = (breakpoint_instruction_in & ~psw_bit23_in) |
				single_step_done_in | (halt_run_press_in & run_mode_in);
		end
		if (init_done_in & ~init_done_prev_q & ~loader_storage_unit_en_in &
			~backup_power_kept_in) begin
			ev_console = 1'b1;
		end
		if (console_flag_pend_q & mem_ack_in & (mem_rdata_in != 32'h0000_0000)) begin
			ev_console = 1'b1;
		end
		if (malf_fetch_uncorr_in) begin
			ev_console = 1'b1;
		end
		ev_detect = (low_voltage_in & ~prev_low_q) | (power_standby_in & ~prev_standby_q) |
			init_press_in;
		ev_early = ev_detect & psw_bit18_in;
		ev_bad = bad_termination_command_in | ctrl_bad_status_in |
			(controller_check_line_in & data_cmd_active_in);
		ev_good = ctrl_sync_in & word_count_done_in;
		unmask_edge = prev_mask_q & ~user_irq_mask_bit_in;
		set_v = '0;
		set_v[mipu_pkg::LVL_CONSOLE] = ev_console;
		set_v[mipu_pkg::LVL_PRIMARY_PF] = primary_power_fail_sensor_in;
		set_v[mipu_pkg::LVL_EARLY_PF] = ev_early;
		set_v[mipu_pkg::LVL_IO_ATTN] = main_bus_attention_in | private_bus_attention_in;
		set_v[mipu_pkg::LVL_DMA_BAD] = ev_bad | (term_lost_q & unmask_edge);
		set_v[mipu_pkg::LVL_DMA_END] = ev_good;
		gate_v = pend_q;
		if (pf_ack_q) begin
			gate_v[2:0] = 3'h0;
		end
		if (pend_q[mipu_pkg::LVL_CONSOLE] & ~run_mode_in) begin
			gate_v[mipu_pkg::LVL_IO_ATTN] = 1'b0;
		end
		enc_bus.pending = gate_v;
		pend_d = pend_q | set_v;
		// Set wins over acknowledge clear
		if (vector_taken_in & busy_q) begin
			pend_d[user_irq_code_out] = set_v[user_irq_code_out];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pend_q <= '0;
			prev_mask_q <= 1'b1;
			prev_low_q <= 1'b0;
			prev_standby_q <= 1'b0;
			init_done_prev_q <= 1'b0;
		end else begin
			pend_q <= pend_d;
			prev_mask_q <= user_irq_mask_bit_in;
			prev_low_q <= low_voltage_in;
			prev_standby_q <= power_standby_in;
			init_done_prev_q <= init_done_in;
		end
	end

	// Lost terminations remembered while masked
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			term_lost_q <= 1'b0;
		end else if (user_irq_mask_bit_in & (ev_good | ev_bad)) begin
			term_lost_q <= 1'b1;
		end else if (unmask_edge) begin
			term_lost_q <= 1'b0;
		end
	end

	// Request and code frozen until the sequencer takes the vector
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			busy_q <= 1'b0;
			user_irq_summary_request_out <= 1'b0;
			user_irq_code_out <= 3'h0;
			vector_addr_out <= mipu_pkg::VEC_L0;
			pf_ack_q <= 1'b0;
		end else if (busy_q) begin
			if (vector_taken_in) begin
				busy_q <= 1'b0;
				user_irq_summary_request_out <= 1'b0;
				if (user_irq_code_out == 3'(mipu_pkg::LVL_EARLY_PF)) begin
					pf_ack_q <= 1'b1;
				end
			end
		end else if (enc_bus.any & ~user_irq_mask_bit_in) begin
			busy_q <= 1'b1;
			user_irq_summary_request_out <= 1'b1;
			user_irq_code_out <= enc_bus.code;
			vector_addr_out <= vec_of(enc_bus.code);
		end
	end

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			machine_malfunction_out <= 1'b0;
		end else begin
			machine_malfunction_out <= instr_boundary_in & psw_bit18_in &
				(pend_q[mipu_pkg::LVL_EARLY_PF] | ev_early);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Power-fail save sequencer; one word per memory acknowledge
	mipu_pkg::mipu_pf_state_t pf_q;
	logic [$clog2(SHUTDOWN_CYC + 1)-1:0] dly_q;
	logic [23:0] base_q;
	logic [9:0] ofs_q;
	logic [9:0] ofs_next;
	logic pf_started_q;

	assign ofs_next = ofs_q + 10'h004;

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			pf_q <= mipu_pkg::PF_IDLE;
			dly_q <= '0;
			base_q <= 24'h00_0000;
			ofs_q <= mipu_pkg::OFS_STATUS;
			pf_started_q <= 1'b0;
		end else begin
			unique case (pf_q)
				mipu_pkg::PF_IDLE: begin
					// Shutdown follows detect even with bit 18 clear
					if (ev_detect) begin
						pf_q <= mipu_pkg::PF_WAIT;
						dly_q <= '0;
					end
				end
				mipu_pkg::PF_WAIT: begin
					if (dly_q == ($bits(dly_q))'(SHUTDOWN_CYC - 1)) begin
						pf_q <= mipu_pkg::PF_PTR;
					end else begin
						dly_q <= dly_q + 1'b1;
					end
				end
				mipu_pkg::PF_PTR: begin
					if (mem_ack_in) begin
						base_q <= {mem_rdata_in[23:2], 2'b00};
						ofs_q <= mipu_pkg::OFS_STATUS;
						pf_q <= mipu_pkg::PF_SAVE;
					end
				end
				mipu_pkg::PF_SAVE: begin
					// No mask bit gates this walk: float and scratch always saved
					if (mem_ack_in) begin
						if (ofs_next == mipu_pkg::OFS_END) begin
							pf_q <= mipu_pkg::PF_HOLD;
						end
						ofs_q <= ofs_next;
					end
				end
				mipu_pkg::PF_HOLD: begin
					if (power_restore_in) begin
						pf_q <= mipu_pkg::PF_IDLE;
					end
				end
			endcase
			pf_started_q <= (pf_q != mipu_pkg::PF_IDLE);
		end
	end

	// Console-flag word read after init with backup power kept
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			console_flag_pend_q <= 1'b0;
		end else if (init_done_in & ~init_done_prev_q & ~loader_storage_unit_en_in &
			backup_power_kept_in) begin
			console_flag_pend_q <= 1'b1;
		end else if (mem_ack_in & (pf_q == mipu_pkg::PF_IDLE)) begin
			console_flag_pend_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			mem_read_out <= 1'b0;
			mem_write_out <= 1'b0;
			mem_addr_out <= 24'h00_0000;
			save_phase_out <= 2'h0;
			shutdown_busy_out <= 1'b0;
			wait_restore_out <= 1'b0;
			io_hold_out <= 1'b0;
		end else begin
			mem_read_out <= (pf_q == mipu_pkg::PF_PTR) |
				(console_flag_pend_q & (pf_q == mipu_pkg::PF_IDLE));
			mem_write_out <= (pf_q == mipu_pkg::PF_SAVE);
			mem_addr_out <= (pf_q == mipu_pkg::PF_PTR) ? mipu_pkg::SAVE_PTR_ADDR :
				(pf_q == mipu_pkg::PF_SAVE) ? base_q + {14'h0000, ofs_q} :
				mipu_pkg::CONSOLE_FLAG_ADDR;
			save_phase_out <= (ofs_q >= mipu_pkg::OFS_FLOAT) ? 2'h3 :
				(ofs_q >= mipu_pkg::OFS_SCRATCH) ? 2'h2 :
				(ofs_q >= mipu_pkg::OFS_REGSETS) ? 2'h1 : 2'h0;
			shutdown_busy_out <= pf_started_q | (pf_q != mipu_pkg::PF_IDLE);
			wait_restore_out <= (pf_q == mipu_pkg::PF_HOLD);
			io_hold_out <= pend_q[mipu_pkg::LVL_CONSOLE] & ~run_mode_in;
		end
	end
endmodule : mipu_top

/* dv/mipu_partner.sv */
// Far side: sequencer taking vectors and memory answering the save walk.
// Assumes requests are levels held until answered by a one-cycle pulse.
`timescale 1ns/100ps
module mipu_partner #(
	parameter logic [31:0] PTR = 32'h0000_4003
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic req_in,
	input wire logic rd_in,
	input wire logic wr_in,
	output logic taken_out,
	output logic ack_out,
	output logic [31:0] rdata_out
);
	logic [2:0] s_q;
	logic [2:0] m_q;
	logic slow_q;
	wire logic sgo = req_in && !taken_out && s_q == (slow_q ? 3'h5 : 3'h1);
	// Writes answered slower than reads; never two acks in adjacent cycles
	wire logic mgo = (rd_in || wr_in) && !ack_out && m_q == {1'b0, wr_in, 1'b1};
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s_q <= 3'h0;
			slow_q <= 1'b0;
			taken_out <= 1'b0;
		end else begin
			taken_out <= sgo;
			s_q <= (req_in && !taken_out) ? s_q + 3'h1 : 3'h0;
			if (taken_out) begin
				slow_q <= !slow_q;
			end
		end
	end
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			m_q <= 3'h0;
			ack_out <= 1'b0;
			rdata_out <= ~PTR;
		end else begin
			ack_out <= mgo;
			m_q <= ((rd_in || wr_in) && !ack_out) ? m_q + 3'h1 : 3'h0;
			// Misaligned pointer; data toggle outside the valid cycle
			rdata_out <= mgo ? PTR : ~rdata_out;
		end
	end
endmodule : mipu_partner

/* dv/mipu_top_asserts.sv */
// Checker on the top-level ports of the user-level interrupt unit.
// Assumes one clock domain; bound into every mipu_top instance.
`timescale 1ns/100ps
module mipu_top_asserts #(
	parameter int SHUTDOWN_CYC = 20
) (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic user_irq_mask_bit_in,
	input wire logic psw_bit18_in,
	input wire logic shutdown_busy_out,
	input wire logic run_mode_in,
	input wire logic vector_taken_in,
	input wire logic user_irq_summary_request_out,
	input wire logic [2:0] user_irq_code_out,
	input wire logic io_hold_out,
	input wire logic machine_malfunction_out,
	input wire logic mem_read_out,
	input wire logic mem_write_out,
	input wire logic [23:0] mem_addr_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (sys_rst_in);
	logic epf_q;
	int cnt_q;
	////////////////////////////////////////////////////////////////////////////////
	// Saturating count keeps the shutdown check cheap over long runs
	always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			epf_q <= 1'b0;
			cnt_q <= 0;
		end else begin
			if (user_irq_summary_request_out && vector_taken_in && user_irq_code_out == 3'h3) begin
				epf_q <= 1'b1;
			end
			if (!shutdown_busy_out) begin
				cnt_q <= 0;
			end else if (cnt_q < SHUTDOWN_CYC + 8) begin
				cnt_q <= cnt_q + 1;
			end
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	req_code_a: assert property (user_irq_summary_request_out |-> user_irq_code_out <= 3'h5)
		else $error("request code out of range");
	mask_gate_a: assert property ($rose(user_irq_summary_request_out) |-> !$past(user_irq_mask_bit_in))
		else $error("request raised while masked");
	code_hold_a: assert property (user_irq_summary_request_out && !vector_taken_in |=>
		user_irq_summary_request_out && $stable(user_irq_code_out))
		else $error("request or code moved before vector taken");
	req_drop_a: assert property (user_irq_summary_request_out && vector_taken_in |=>
		!user_irq_summary_request_out)
		else $error("request kept after vector taken");
	hold_run_a: assert property (io_hold_out |-> !$past(run_mode_in))
		else $error("io held in run mode");
	malf_bit_a: assert property (machine_malfunction_out |-> $past(psw_bit18_in))
		else $error("malfunction without status bit");
	epf_bit_a: assert property (user_irq_summary_request_out && user_irq_code_out == 3'h3 |->
		psw_bit18_in)
		else $error("early fail request without status bit");
	low_gate_a: assert property (user_irq_summary_request_out && epf_q |-> user_irq_code_out >= 3'h3)
		else $error("lower level after early fail ack");
	ptr_addr_a: assert property (mem_read_out && shutdown_busy_out |-> mem_addr_out == 24'h00_0084)
		else $error("pointer read at wrong address");
	flag_addr_a: assert property (mem_read_out && !shutdown_busy_out |-> mem_addr_out == 24'h00_0028)
		else $error("console flag read at wrong address");
	save_align_a: assert property (mem_write_out |-> mem_addr_out[1:0] == 2'h0)
		else $error("save write not word aligned");
	shut_delay_a: assert property ($rose(mem_read_out) && shutdown_busy_out |-> cnt_q >= SHUTDOWN_CYC)
		else $error("shutdown began too early");
	cover property ($rose(user_irq_summary_request_out) && user_irq_code_out == 3'h5);
	cover property ($rose(mem_write_out));
	cover property (machine_malfunction_out);
	cover property (mem_read_out && !shutdown_busy_out);
endmodule : mipu_top_asserts
bind mipu_top mipu_top_asserts #(.SHUTDOWN_CYC(SHUTDOWN_CYC)) u_asserts (.core_clk_in, .sys_rst_in,
	.user_irq_mask_bit_in, .psw_bit18_in, .shutdown_busy_out, .run_mode_in, .vector_taken_in,
	.user_irq_summary_request_out, .user_irq_code_out, .io_hold_out, .machine_malfunction_out,
	.mem_read_out, .mem_write_out, .mem_addr_out);

/* dv/test_macrointerrupt_priority_unit.sv */
// Self-checking bench for the user-level interrupt priority unit.
// Assumes mipu_partner answers the vector and memory requests.
`timescale 1ns/100ps
module test_macrointerrupt_priority_unit;
	logic clk = 0, rst = 1, msk = 0, run = 0, b18 = 0, lv = 0, wcd = 0, bnd = 0, prs = 0;
	logic cm = 1, b23 = 0, bk = 0;
	logic [14:0] ev = '0;
	logic req, req_q = 0, rd, wr, ack, tkn, hold, malf, busy, wrs;
	logic [2:0] code;
	logic [11:0] vec;
	logic [23:0] addr;
	logic [31:0] rdat;
	logic [1:0] ph;
	logic [14:0] vq [$];
	logic [25:0] aq [$];
	logic [11:0] vt [6] = '{12'hDFF, 12'hDF7, 12'hDFB, 12'hDF3, 12'hDFD, 12'hDF5};
	int lvl [5] = '{5, 4, 2, 1, 0};
	int n_mismatch = 0;
	int check_count = 0;
	mipu_top #(.SHUTDOWN_CYC(20)) u_dut (.core_clk_in(clk), .sys_rst_in(rst),
		.user_irq_mask_bit_in(msk), .psw_bit23_in(b23), .psw_bit18_in(b18),
		.console_mode_in(cm), .run_mode_in(run), .breakpoint_instruction_in(ev[0]),
		.single_step_done_in(ev[1]), .halt_run_press_in(ev[2]), .init_done_in(ev[4]),
		.loader_storage_unit_en_in(1'b0), .backup_power_kept_in(bk),
		.malf_fetch_uncorr_in(ev[3]), .primary_power_fail_sensor_in(ev[5]),
		.low_voltage_in(lv), .power_standby_in(ev[13]), .init_press_in(ev[14]),
		.instr_boundary_in(bnd), .main_bus_attention_in(ev[6]),
		.private_bus_attention_in(ev[7]), .bad_termination_command_in(ev[8]),
		.ctrl_bad_status_in(ev[9]), .controller_check_line_in(ev[10]),
		.data_cmd_active_in(ev[11]), .word_count_done_in(wcd), .ctrl_sync_in(ev[12]),
		.vector_taken_in(tkn), .mem_ack_in(ack), .mem_rdata_in(rdat),
		.power_restore_in(prs), .user_irq_summary_request_out(req),
		.user_irq_code_out(code), .vector_addr_out(vec), .io_hold_out(hold),
		.machine_malfunction_out(malf), .mem_read_out(rd), .mem_write_out(wr),
		.mem_addr_out(addr), .save_phase_out(ph), .shutdown_busy_out(busy),
		.wait_restore_out(wrs));
	mipu_partner u_far (.clk_in(clk), .rst_in(rst), .req_in(req), .rd_in(rd), .wr_in(wr),
		.taken_out(tkn), .ack_out(ack), .rdata_out(rdat));
	////////////////////////////////////////////////////////////////////////////////
	task automatic note(input logic ok, input string s);
		check_count++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("unexpected at %0t: %s", $time, s);
		end
	endtask : note
	task automatic cmp_vec(input logic [14:0] got);
		note(vq.size() > 0 && got === vq.pop_front(), "code or vector");
	endtask : cmp_vec
	task automatic cmp_mem(input logic [25:0] got);
		note(aq.size() > 0 && got === aq.pop_front(), "save phase or address");
	endtask : cmp_mem
	task automatic fire(input logic [14:0] m);
		ev <= m;
		@(posedge clk);
		ev <= '0;
	endtask : fire
	// Bounded wait so a stuck request cannot hang the run
	task automatic drain(input int n);
		repeat (n) begin
			@(posedge clk);
			if (vq.size() == 0 && aq.size() == 0 && req !== 1'b1) break;
		end
		note(vq.size() == 0 && aq.size() == 0, "results still outstanding");
	endtask : drain
	task automatic results();
		$display("mismatches %0d, checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : results
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		if (!rst && req && !req_q) cmp_vec({code, vec});
		if (!rst && ack && (rd || wr)) cmp_mem({wr ? ph : 2'h0, addr});
		req_q <= req;
	end
	initial begin
		forever #5 clk = ~clk;
	end
	initial begin
		#200000;
		n_mismatch++;
		results();
	end
	initial begin
		int c;
		void'($urandom(34));
		repeat (8) @(posedge clk);
		rst <= 0;
		repeat (2) @(posedge clk);
		// Console events outside console mode, and breakpoint with bit 23 set
		cm <= 0;
		fire(15'h0003);
		cm <= 1;
		b23 <= 1;
		@(posedge clk);
		fire(15'h0001);
		b23 <= 0;
		repeat (4) @(posedge clk);
		note(req === 1'b0, "console event ignored");
		// Backup power kept: flag word read, nonzero data raises console
		bk <= 1;
		aq.push_back({2'h0, 24'h00_0028});
		vq.push_back({3'h5, vt[5]});
		fire(15'h0010);
		drain(100);
		bk <= 0;
		// Round 0 masked with no bad event: level 1 must come from the lost end
		for (int r = 0; r < 4; r++) begin
			msk <= (r == 0);
			run <= (r != 0);
			wcd <= 1;
			c = $urandom_range(2, 0);
			foreach (lvl[i]) vq.push_back({lvl[i][2:0], vt[lvl[i]]});
			fire((15'h0001 << (r ? 2 + c : c % 2)) | 15'h1020 | (15'h0040 << (c % 2)) |
				(r == 0 ? 15'h0000 : r == 3 ? 15'h0C00 : 15'h0080 << r));
			repeat (10) @(posedge clk);
			note(hold === (r == 0), "console hold");
			msk <= 0;
			drain(300);
		end
		b18 <= 1;
		bnd <= 1;
		@(posedge clk);
		lv <= 1;
		vq.push_back({3'h3, vt[3]});
		aq.push_back({2'h0, 24'h00_0084});
		// Base is the partner pointer with its two low bits cleared
		for (int o = 0; o < 'h2A8; o += 4) aq.push_back({o < 8 ? 2'h0 : o < 'h208 ? 2'h1 :
			o < 'h248 ? 2'h2 : 2'h3, 24'h00_4000 + o[23:0]});
		fire(15'h6000);
		note(malf === 1'b0, "malfunction before early fail");
		bnd <= 0;
		@(posedge clk);
		note(malf === 1'b1, "no malfunction at boundary");
		repeat (15) @(posedge clk);
		// Level 4 still served after the early fail ack, levels 2 and 1 not
		vq.push_back({3'h4, vt[4]});
		fire(15'h0360);
		drain(2000);
		// Hold state shows two edges after the last save acknowledge
		repeat (2) @(posedge clk);
		note(wrs === 1'b1 && busy === 1'b1, "not waiting for restore");
		prs <= 1;
		repeat (3) @(posedge clk);
		rst <= 1;
		lv <= 0;
		b18 <= 0;
		repeat (3) @(posedge clk);
		rst <= 0;
		prs <= 0;
		repeat (3) @(posedge clk);
		note(req === 1'b0 && wrs === 1'b0 && busy === 1'b0, "state after reset");
		results();
	end
endmodule : test_macrointerrupt_priority_unit
